// ---- common/esp_cfg.svh ----
// constants for the enhanced serial port: mode codes, bit counts, timing
`ifndef ESP_CFG_SVH
`define ESP_CFG_SVH

// select mode field codes and field bits
`define ESP_MODE_3WIRE 2'h0
`define ESP_MODE_4W_IN 2'h1
`define ESP_MODE_RST 2'h1
`define ESP_SEL_OUT_BIT 1
`define ESP_SEL_LVL_BIT 0

// byte framing
`define ESP_LAST_BIT 3'h7
`define ESP_IDLE_BYTE 8'hFF

// master serial clock: half period in ns and in system clocks (rounded up)
`define ESP_SYS_NS 20
`define ESP_SCK_HALF_NS 160
`define ESP_HALF_CYC ((`ESP_SCK_HALF_NS + `ESP_SYS_NS - 1) / `ESP_SYS_NS)

`endif

// ---- common/esp_pkg.sv ----
// types shared by the enhanced serial port design
package esp_pkg;
   typedef enum logic {ESP_M_IDLE, ESP_M_SHIFT} esp_mst_e;
endpackage

// ---- logic/esp_sync.sv ----
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/10ps
module esp_sync
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // data
   input wire logic d_i,
   output logic q_o
);
   logic f1_q;
   logic f2_q;
   logic f3_q;
   logic out_q;
   logic out_d;

   always_comb
   begin
      out_d = (f2_q == f3_q) ? f3_q : out_q;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         f1_q <= 1'b0;
         f2_q <= 1'b0;
         f3_q <= 1'b0;
         out_q <= 1'b0;
      end
      else
      begin
         f1_q <= d_i;
         f2_q <= f1_q;
         f3_q <= f2_q;
         out_q <= out_d;
      end
   end

   assign q_o = out_q;
endmodule

// ---- logic/esp_core.sv ----
// enhanced serial port: master/slave shifter, pin direction and select modes
// Overview of operation
// - master-out driven as master, input as slave
// - both lines MSB first from shifter top
// - master-in input as master, driven as slave
// - master-in floats when disabled or deselected
// - 3-wire slave drives master-in from shifter top
// - master makes serial clock, slave receives it
// - deselected 4-wire slave ignores clock edges
// - mode 00: 3-wire, slave always selected
// - mode 01: 4-wire, select is input
// - mode 01 master: select fall drops master
// - mode 1x: select driven from level bit
// - select pin mapped except in 3-wire mode
// - master and slave, 3/4-wire, full duplex
// - mode fault clears enables, sets fault flag
// - mode 01: select rise resets slave bit counter
// - slave: eighth bit sets done, fills receive or flags overrun if unread
// - master: written byte loads shifter, starts transfer
`timescale 1ns/10ps
`include "esp_cfg.svh"
module esp_core
(
   // system clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // control write
   input wire logic ctl_wr_i,
   input wire logic port_enable_bit_i,
   input wire logic master_role_enable_i,
   input wire logic [1:0] select_mode_field_i,
   // data register
   input wire logic data_wr_i,
   input wire logic [7:0] data_wr_val_i,
   input wire logic data_rd_i,
   output logic [7:0] port_data_register_o,
   // flag clears
   input wire logic done_clr_i,
   input wire logic wcol_clr_i,
   input wire logic mode_fault_flag_clr_i,
   input wire logic ovr_clr_i,
   // status
   output logic port_enable_bit_o,
   output logic master_role_enable_o,
   output logic [1:0] select_mode_field_o,
   output logic transfer_done_flag_o,
   output logic write_collision_flag_o,
   output logic mode_fault_flag_o,
   output logic rx_overrun_flag_o,
   output logic tx_buffer_empty_o,
   // serial clock pin
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe_o,
   // master-out pin
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe_o,
   // master-in pin
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe_o,
   // slave select pin
   input wire logic nss_b_i,
   output logic nss_b_o,
   output logic nss_oe_o,
   output logic nss_pin_map_o
);
   localparam logic [3:0] HALF_LAST = 4'(`ESP_HALF_CYC - 1);

   // system domain state
   logic port_en_q, port_en_d;
   logic master_q, master_d;
   logic [1:0] mode_q, mode_d;
   logic [7:0] tx_buf_q, tx_buf_d;
   logic tx_full_q, tx_full_d;
   logic req_q, req_d;
   logic [7:0] rx_buf_q, rx_buf_d;
   logic unread_q, unread_d;
   logic done_q, done_d;
   logic wcol_q, wcol_d;
   logic mode_fault_flag_q, mode_fault_flag_d;
   logic ovr_q, ovr_d;
   esp_pkg::esp_mst_e mst_q, mst_d;
   logic [3:0] div_q, div_d;
   logic [2:0] mcnt_q, mcnt_d;
   logic [7:0] msh_q, msh_d;
   logic mbit_q, mbit_d;
   logic sck_q, sck_d;
   logic nss_prev_q, nss_prev_d;
   logic done_prev_q, done_prev_d;
   logic ack_prev_q, ack_prev_d;

   // link domain state
   logic [2:0] lcnt_q, lcnt_d;
   logic [7:0] lsh_q, lsh_d;
   logic [7:0] lrx_q, lrx_d;
   logic ldone_q, ldone_d;
   logic lack_q, lack_d;
   logic [7:0] lsrc;
   logic lpend;

   // synchronised signals
   logic nss_s;
   logic miso_s;
   logic done_s;
   logic ack_s;
   logic req_l;

   logic selected;
   logic slave_act;
   logic link_rst_b;

   esp_sync u_sync_nss (.clk_i(clk_sys_i), .rst_b_i(rst_b_i), .d_i(nss_b_i), .q_o(nss_s));
   esp_sync u_sync_miso (.clk_i(clk_sys_i), .rst_b_i(rst_b_i), .d_i(miso_i), .q_o(miso_s));
   esp_sync u_sync_done (.clk_i(clk_sys_i), .rst_b_i(rst_b_i), .d_i(ldone_q), .q_o(done_s));
   esp_sync u_sync_ack (.clk_i(clk_sys_i), .rst_b_i(rst_b_i), .d_i(lack_q), .q_o(ack_s));
   esp_sync u_sync_req (.clk_i(sck_i), .rst_b_i(rst_b_i), .d_i(req_q), .q_o(req_l));

   // select: always on in 3-wire and output modes, else low pin level
   assign selected = (mode_q == `ESP_MODE_3WIRE) || mode_q[`ESP_SEL_OUT_BIT] || !nss_b_i;
   assign slave_act = port_en_q && !master_q;
   // held in reset while deselected, so edges are ignored and count restarts
   assign link_rst_b = rst_b_i && slave_act && selected;

   // system domain next state
   always_comb
   begin
      port_en_d = port_en_q;
      master_d = master_q;
      mode_d = mode_q;
      tx_buf_d = tx_buf_q;
      tx_full_d = tx_full_q;
      req_d = req_q;
      rx_buf_d = rx_buf_q;
      unread_d = unread_q;
      done_d = done_q;
      wcol_d = wcol_q;
      mode_fault_flag_d = mode_fault_flag_q;
      ovr_d = ovr_q;
      mst_d = mst_q;
      div_d = div_q;
      mcnt_d = mcnt_q;
      msh_d = msh_q;
      mbit_d = mbit_q;
      sck_d = sck_q;
      nss_prev_d = nss_s;
      done_prev_d = done_s;
      ack_prev_d = ack_s;
      if (ctl_wr_i)
      begin
         port_en_d = port_enable_bit_i;
         master_d = master_role_enable_i;
         mode_d = select_mode_field_i;
      end
      // clears first so a same-cycle set wins
      if (done_clr_i)
         done_d = 1'b0;
      if (wcol_clr_i)
         wcol_d = 1'b0;
      if (mode_fault_flag_clr_i)
         mode_fault_flag_d = 1'b0;
      if (ovr_clr_i)
         ovr_d = 1'b0;
      if (data_rd_i)
         unread_d = 1'b0;
      if (data_wr_i)
      begin
         if (tx_full_q)
            wcol_d = 1'b1;
         else
         begin
            tx_buf_d = data_wr_val_i;
            tx_full_d = 1'b1;
            if (!master_q)
               req_d = !req_q;
         end
      end
      // slave shifter took the buffered byte
      if (ack_s != ack_prev_q)
         tx_full_d = 1'b0;
      // slave byte complete in link domain
      if (done_s != done_prev_q)
      begin
         done_d = 1'b1;
         if (unread_q && !data_rd_i)
            ovr_d = 1'b1;
         else
         begin
            rx_buf_d = lrx_q;
            unread_d = 1'b1;
         end
      end
      case (mst_q)
         esp_pkg::ESP_M_IDLE:
         begin
            sck_d = 1'b0;
            if (port_en_q && master_q && tx_full_q)
            begin
               msh_d = tx_buf_q;
               tx_full_d = 1'b0;
               mcnt_d = 3'h0;
               div_d = 4'h0;
               mst_d = esp_pkg::ESP_M_SHIFT;
            end
         end
         esp_pkg::ESP_M_SHIFT:
         begin
            div_d = div_q + 4'h1;
            if (div_q == HALF_LAST)
            begin
               div_d = 4'h0;
               if (!sck_q)
               begin
                  sck_d = 1'b1;
                  mbit_d = miso_s;
               end
               else
               begin
                  sck_d = 1'b0;
                  msh_d = {msh_q[6:0], mbit_q};
                  mcnt_d = mcnt_q + 3'h1;
                  if (mcnt_q == `ESP_LAST_BIT)
                  begin
                     done_d = 1'b1;
                     rx_buf_d = {msh_q[6:0], mbit_q};
                     unread_d = 1'b1;
                     mst_d = esp_pkg::ESP_M_IDLE;
                  end
               end
            end
         end
         default:
         begin
            mst_d = esp_pkg::ESP_M_IDLE;
         end
      endcase
      // another master pulled select low
      if ((mode_q == `ESP_MODE_4W_IN) && master_q && nss_prev_q && !nss_s)
      begin
         master_d = 1'b0;
         port_en_d = 1'b0;
         mode_fault_flag_d = 1'b1;
      end
      if (!port_en_q || !master_q)
      begin
         mst_d = esp_pkg::ESP_M_IDLE;
         sck_d = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         port_en_q <= 1'b0;
         master_q <= 1'b0;
         mode_q <= `ESP_MODE_RST;
         tx_buf_q <= 8'h00;
         tx_full_q <= 1'b0;
         req_q <= 1'b0;
         rx_buf_q <= 8'h00;
         unread_q <= 1'b0;
         done_q <= 1'b0;
         wcol_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         ovr_q <= 1'b0;
         mst_q <= esp_pkg::ESP_M_IDLE;
         div_q <= 4'h0;
         mcnt_q <= 3'h0;
         msh_q <= 8'h00;
         mbit_q <= 1'b0;
         sck_q <= 1'b0;
         nss_prev_q <= 1'b1;
         done_prev_q <= 1'b0;
         ack_prev_q <= 1'b0;
      end
      else
      begin
         port_en_q <= port_en_d;
         master_q <= master_d;
         mode_q <= mode_d;
         tx_buf_q <= tx_buf_d;
         tx_full_q <= tx_full_d;
         req_q <= req_d;
         rx_buf_q <= rx_buf_d;
         unread_q <= unread_d;
         done_q <= done_d;
         wcol_q <= wcol_d;
         mode_fault_flag_q <= mode_fault_flag_d;
         ovr_q <= ovr_d;
         mst_q <= mst_d;
         div_q <= div_d;
         mcnt_q <= mcnt_d;
         msh_q <= msh_d;
         mbit_q <= mbit_d;
         sck_q <= sck_d;
         nss_prev_q <= nss_prev_d;
         done_prev_q <= done_prev_d;
         ack_prev_q <= ack_prev_d;
      end
   end

   // link domain: sample on rising serial clock, byte source at bit zero
   always_comb
   begin
      lpend = (req_l != lack_q);
      lsrc = (lcnt_q == 3'h0) ? (lpend ? tx_buf_q : `ESP_IDLE_BYTE) : lsh_q;
      lsh_d = {lsrc[6:0], mosi_i};
      lcnt_d = lcnt_q + 3'h1;
      lrx_d = lrx_q;
      ldone_d = ldone_q;
      lack_d = lack_q;
      // a deselected slave must not consume the buffered byte
      if ((lcnt_q == 3'h0) && lpend && slave_act && selected)
         lack_d = !lack_q;
      if (lcnt_q == `ESP_LAST_BIT)
      begin
         lrx_d = lsh_d;
         ldone_d = !ldone_q;
      end
   end

   always_ff @(posedge sck_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         lcnt_q <= 3'h0;
         lsh_q <= 8'h00;
      end
      else
      begin
         lcnt_q <= lcnt_d;
         lsh_q <= lsh_d;
      end
   end

   // toggles survive select resets so no event is faked or lost
   always_ff @(posedge sck_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lrx_q <= 8'h00;
         ldone_q <= 1'b0;
         lack_q <= 1'b0;
      end
      else
      begin
         lrx_q <= lrx_d;
         ldone_q <= ldone_d;
         lack_q <= lack_d;
      end
   end

   // pin directions
   assign sck_o = sck_q;
   assign sck_oe_o = port_en_q && master_q;
   assign mosi_o = msh_q[7];
   assign mosi_oe_o = port_en_q && master_q;
   assign miso_o = lsrc[7];
   assign miso_oe_o = slave_act && selected;
   assign nss_b_o = mode_q[`ESP_SEL_LVL_BIT];
   assign nss_oe_o = mode_q[`ESP_SEL_OUT_BIT];
   assign nss_pin_map_o = (mode_q != `ESP_MODE_3WIRE);

   // status
   assign port_data_register_o = rx_buf_q;
   assign port_enable_bit_o = port_en_q;
   assign master_role_enable_o = master_q;
   assign select_mode_field_o = mode_q;
   assign transfer_done_flag_o = done_q;
   assign write_collision_flag_o = wcol_q;
   assign mode_fault_flag_o = mode_fault_flag_q;
   assign rx_overrun_flag_o = ovr_q;
   assign tx_buffer_empty_o = !tx_full_q;
endmodule

// ---- test/esp_core_assertions.sv ----
// checker on the enhanced serial port core pins
`timescale 1ns/10ps
module esp_core_chk
(
   // clock, reset, requests
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic ctl_wr_i,
   input wire logic data_wr_i,
   input wire logic nss_b_i,
   input wire logic [1:0] select_mode_field_i,
   // status and pins
   input wire logic [1:0] select_mode_field_o,
   input wire logic port_enable_bit_o,
   input wire logic master_role_enable_o,
   input wire logic mode_fault_flag_o,
   input wire logic tx_buffer_empty_o,
   input wire logic sck_o,
   input wire logic sck_oe_o,
   input wire logic mosi_o,
   input wire logic mosi_oe_o,
   input wire logic miso_oe_o,
   input wire logic nss_b_o,
   input wire logic nss_oe_o,
   input wire logic nss_pin_map_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   mosi_dir_a: assert property (mosi_oe_o == (port_enable_bit_o && master_role_enable_o))
      else $error("master-out enable wrong");
   miso_dir_a: assert property (miso_oe_o |-> port_enable_bit_o && !master_role_enable_o)
      else $error("master-in driven wrongly");
   miso_float_a: assert property (select_mode_field_o == 2'h1 && nss_b_i |-> !miso_oe_o)
      else $error("master-in driven while deselected");
   sck_gen_a: assert property (sck_oe_o |-> master_role_enable_o && port_enable_bit_o)
      else $error("serial clock driven as slave");
   sel_out_a: assert property (nss_oe_o == select_mode_field_o[1]
      && (!nss_oe_o || nss_b_o == select_mode_field_o[0]))
      else $error("select output wrong");
   pin_map_a: assert property (nss_pin_map_o == (select_mode_field_o != 2'h0))
      else $error("select pin mapping wrong");
   mode_take_a: assert property (ctl_wr_i |=> select_mode_field_o == $past(select_mode_field_i))
      else $error("mode not taken");
   mst_fault_a: assert property ($fell(nss_b_i) && select_mode_field_o == 2'h1
      && master_role_enable_o && port_enable_bit_o |-> ##[1:6] mode_fault_flag_o
      && !master_role_enable_o && !port_enable_bit_o)
      else $error("mode fault not taken");
   mosi_hold_a: assert property (sck_o && $past(sck_o) |-> $stable(mosi_o))
      else $error("master-out moved while clock high");
   tx_load_a: assert property (data_wr_i && tx_buffer_empty_o |=> !tx_buffer_empty_o)
      else $error("write not taken");
endmodule
bind esp_core esp_core_chk u_chk (.clk_sys_i, .rst_b_i, .ctl_wr_i, .data_wr_i, .nss_b_i,
   .select_mode_field_i, .select_mode_field_o, .port_enable_bit_o, .master_role_enable_o,
   .mode_fault_flag_o, .tx_buffer_empty_o, .sck_o, .sck_oe_o, .mosi_o, .mosi_oe_o,
   .miso_oe_o, .nss_b_o, .nss_oe_o, .nss_pin_map_o);

// ---- test/esp_peer.sv ----
// far-side model: external serial master and slave
`timescale 1ns/10ps
module esp_peer
(
   // from the port
   input wire logic sck_m_i,
   input wire logic mosi_m_i,
   input wire logic miso_s_i,
   // to the port
   output logic sck_o,
   output logic mosi_o,
   output logic miso_o
);
   logic [7:0] tx_q = 8'h00;
   logic [7:0] rx_q = 8'h00;
   initial
   begin
      sck_o = 1'b0;
      mosi_o = 1'b0;
   end
   // slave role, the only one on the bus
   assign miso_o = tx_q[7];
   always @(posedge sck_m_i)
   begin
      rx_q = {rx_q[6:0], mosi_m_i};
   end
   always @(negedge sck_m_i)
   begin
      tx_q = tx_q << 1;
   end
   // master role: the top n bits of one byte (all 8 by default), clock only within the frame
   task automatic frame(input logic [7:0] b, input int n = 8);
      for (int i = 7; i > 7 - n; i--)
      begin
         mosi_o = b[i];
         #62.5 sck_o = 1'b1;
         rx_q = {rx_q[6:0], miso_s_i};
         #62.5 sck_o = 1'b0;
      end
      mosi_o = ~mosi_o;
   endtask
endmodule

// ---- test/esp_core_test.sv ----
// self-checking bench for the enhanced serial port core
`timescale 1ns/10ps
module esp_core_test;
   logic clk_sys_i = 1'b0, rst_b_i = 1'b1, ctl_wr_i = 1'b0, data_wr_i = 1'b0;
   logic data_rd_i = 1'b0, done_clr_i = 1'b0, mode_fault_flag_clr_i = 1'b0, nss_b_i = 1'b0;
   logic port_enable_bit_i = 1'b0, master_role_enable_i = 1'b0;
   logic wcol_clr_i = 1'b0, ovr_clr_i = 1'b0;
   logic [1:0] select_mode_field_i = 2'h1, select_mode_field_o;
   logic [7:0] data_wr_val_i = 8'h00, port_data_register_o;
   logic port_enable_bit_o, master_role_enable_o, transfer_done_flag_o;
   logic write_collision_flag_o, mode_fault_flag_o, rx_overrun_flag_o, tx_buffer_empty_o;
   logic sck_i, sck_o, sck_oe_o, mosi_i, mosi_o, mosi_oe_o, miso_i, miso_o, miso_oe_o;
   logic nss_b_o, nss_oe_o, nss_pin_map_o, pmiso;
   int error_cnt = 0, n_tests = 0;
   logic [10:0] rows [7];
   always #10 clk_sys_i = ~clk_sys_i;
   assign miso_i = miso_oe_o ? miso_o : pmiso;
   esp_core DUT (.*);
   esp_peer peer (.sck_m_i(sck_o), .mosi_m_i(mosi_o), .miso_s_i(miso_i),
      .sck_o(sck_i), .mosi_o(mosi_i), .miso_o(pmiso));
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (error_cnt == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(1);
   endtask
   // enable, master, mode
   task automatic ctl(input logic [3:0] v);
      {port_enable_bit_i, master_role_enable_i, select_mode_field_i} = v;
      pulse(ctl_wr_i);
      tick(1);
   endtask
   task automatic wait_done(input int n);
      while (transfer_done_flag_o !== 1'b1 && n > 0)
      begin
         tick(1);
         n--;
      end
      if (transfer_done_flag_o !== 1'b1)
      begin
         error_cnt++;
         final_report;
      end
   endtask
   task automatic slave_byte(input logic [7:0] b);
      #7 peer.frame(b);
      tick(1);
      wait_done(20);
      chk(port_data_register_o, b);
      pulse(data_rd_i);
      pulse(done_clr_i);
   endtask
   initial
   begin
      // select in, enable, master, mode, then expected enables and levels
      rows = '{11'h208, 11'h24B, 11'h3B5, 11'h3F7, 11'h043, 11'h330, 11'h643};
      // a real falling edge, so flops on the link clock reset too
      #1 rst_b_i = 1'b0;
      repeat (10) @(posedge clk_sys_i);
      #1 rst_b_i = 1'b1;
      tick(1);
      chk({tx_buffer_empty_o, port_enable_bit_o, mode_fault_flag_o, transfer_done_flag_o,
         nss_pin_map_o, nss_oe_o, select_mode_field_o}, 8'h89);
      for (int i = 0; i < 7; i++)
      begin
         nss_b_i = rows[i][10];
         ctl(rows[i][9:6]);
         chk({2'h0, mosi_oe_o, sck_oe_o, miso_oe_o, nss_oe_o, nss_b_o, nss_pin_map_o},
            {2'h0, rows[i][5:0]});
      end
      ctl(4'hE);
      peer.tx_q = 8'h5A;
      data_wr_val_i = 8'hC3;
      pulse(data_wr_i);
      wait_done(400);
      chk(port_data_register_o, 8'h5A);
      chk(peer.rx_q, 8'hC3);
      pulse(data_rd_i);
      pulse(done_clr_i);
      nss_b_i = 1'b1;
      ctl(4'hD);
      nss_b_i = 1'b0;
      tick(8);
      chk({5'h0, mode_fault_flag_o, master_role_enable_o, port_enable_bit_o}, 8'h04);
      pulse(mode_fault_flag_clr_i);
      chk({7'h0, mode_fault_flag_o}, 8'h00);
      ctl(4'h9);
      slave_byte(8'h3C);
      // partial byte, cleared from the bit counter by deselect
      #7 peer.frame(8'hA5, 3);
      tick(2);
      nss_b_i = 1'b1;
      tick(2);
      #7 peer.frame(8'hA5);
      tick(10);
      chk({7'h0, transfer_done_flag_o}, 8'h00);
      nss_b_i = 1'b0;
      tick(3);
      slave_byte(8'h81);
      nss_b_i = 1'b1;
      ctl(4'h8);
      slave_byte(8'h42);
      data_wr_val_i = 8'h96;
      pulse(data_wr_i);
      data_wr_val_i = 8'h69;
      pulse(data_wr_i);
      chk({7'h0, write_collision_flag_o}, 8'h01);
      pulse(wcol_clr_i);
      chk({7'h0, write_collision_flag_o}, 8'h00);
      // buffered byte reaches the link during the first frame, goes out in the second
      slave_byte(8'h11);
      slave_byte(8'h22);
      chk(peer.rx_q, 8'h96);
      #7 peer.frame(8'h33);
      tick(8);
      #7 peer.frame(8'h44);
      tick(8);
      chk({7'h0, rx_overrun_flag_o}, 8'h01);
      chk(port_data_register_o, 8'h33);
      final_report;
   end
endmodule
